/* File: hdl/spo_top.sv */
// stepper status outputs, pulse outputs and current settings, APB slave
`timescale 1ns/1ps
`include "spo_regs.svh"
module spo_top #(
    parameter int unsigned EXCITE_CYCLES = `SPO_EXCITE_CYCLES // settle time before misstep
) (
    input wire logic pclk,                 // 50 MHz clock
    input wire logic presetn,              // async reset, active low
    input wire logic psel,                 // apb select
    input wire logic penable,              // apb access phase
    input wire logic pwrite,               // apb direction
    input wire logic [7:0] paddr,          // apb byte address
    input wire logic [31:0] pwdata,        // apb write data
    output logic [31:0] prdata,            // apb read data
    output logic pready,                   // apb ready
    output logic pslverr,                  // apb error
    input wire logic home_seek_done,       // homing finished pulse
    input wire logic home_seek_active,     // homing in progress
    input wire logic preset_apply,         // position preset pulse
    input wire logic excited,              // windings energised
    input wire logic motor_at_rest,        // motor stopped
    input wire logic [23:0] cmd_pos,       // commanded position
    input wire logic [23:0] enc_count,     // encoder counter
    input wire logic encoder_attached,     // encoder present
    input wire logic encoder_index_in,     // encoder index
    input wire logic overheat_warn,        // overheat warning level
    output logic pos_clear_req,            // counter clear pulse
    output logic home_ready_out,           // home ready
    output logic index_echo_out,           // index echo
    output logic [3:0] remote_general_out, // remote outputs
    output logic overheat_out,             // overheat flag
    output logic misstep_out,              // misstep flag
    output logic step_pulse_out,           // step pulses
    output logic dir_out,                  // direction
    output logic [8:0] div_x2,             // microstep divisions times two
    output logic [6:0] coil_current_pct,   // present current setting
    output logic [15:0] accel_rate,        // accel, 0.001 ms/kHz
    output logic [15:0] decel_rate,        // decel, 0.001 ms/kHz
    output logic irq                       // interrupt, active high
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // divisions times two, so 2.5 and 1 stay integer
    function automatic logic [8:0] res_to_div_x2(input logic [3:0] res);
        logic [8:0] d;
        d = 9'h002;
        unique case (res)
            4'h0: d = 9'h002;
            4'h1: d = 9'h004;
            4'h2: d = 9'h005;
            4'h3: d = 9'h008;
            4'h4: d = 9'h00A;
            4'h5: d = 9'h010;
            4'h6: d = 9'h014;
            4'h7: d = 9'h028;
            4'h8: d = 9'h032;
            4'h9: d = 9'h050;
            4'hA: d = 9'h064;
            4'hB: d = 9'h0A0;
            4'hC: d = 9'h0C8;
            4'hD: d = 9'h0FA;
            4'hE: d = 9'h190;
            4'hF: d = 9'h1F4;
        endcase
        return d;
    endfunction : res_to_div_x2

    // limit a percentage to a range
    function automatic logic [6:0] clamp_pct(input logic [7:0] v, input logic [6:0] lo,
                                             input logic [6:0] hi);
        logic [6:0] r;
        r = v[6:0];
        if (v < {1'b0, lo}) r = lo;
        else if (v > {1'b0, hi}) r = hi;
        return r;
    endfunction : clamp_pct

    // absolute difference of two counts
    function automatic logic [23:0] abs_diff(input logic [23:0] a, input logic [23:0] b);
        logic [23:0] d;
        d = a - b;
        if (d[23]) d = b - a;
        return d;
    endfunction : abs_diff

    // ------------------------------------------------------------
    // registers and state
    // ------------------------------------------------------------
    logic [3:0] res_sel;
    logic misstep_en;
    logic [6:0] run_pct;
    logic [6:0] still_pct;
    logic [15:0] band;
    logic [15:0] period;
    logic [`SPO_EV_COUNT-1:0] status;
    logic [`SPO_EV_COUNT-1:0] mask;
    logic home_set;
    logic excited_q;
    logic [24:0] excite_cnt;
    logic index_q;
    logic home_ready_q;
    logic overheat_q;
    logic misstep_q;
    logic [23:0] mv_travel;
    logic mv_dir;
    logic mv_start;
    logic [8:0] div_q;
    logic [6:0] cur_q;

    spo_step_if st ();

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire acc = psel && penable;
    wire wr = acc && pwrite;
    wire rd = acc && !pwrite;
    wire hit_ctrl = (paddr == `SPO_OFS_CTRL);
    wire hit_cur = (paddr == `SPO_OFS_CURRENT);
    wire hit_acc = (paddr == `SPO_OFS_ACCEL);
    wire hit_band = (paddr == `SPO_OFS_BAND);
    wire hit_move = (paddr == `SPO_OFS_MOVE);
    wire hit_per = (paddr == `SPO_OFS_PERIOD);
    wire hit_cmd = (paddr == `SPO_OFS_CMD);
    wire hit_stat = (paddr == `SPO_OFS_STATUS);
    wire hit_mask = (paddr == `SPO_OFS_MASK);
    wire hit_state = (paddr == `SPO_OFS_STATE);
    wire mapped = hit_ctrl | hit_cur | hit_acc | hit_band | hit_move | hit_per |
                  hit_cmd | hit_stat | hit_mask | hit_state;
    wire clear_cmd = wr && hit_cmd && pwdata[`SPO_CMD_CLEAR_BIT];

    assign pready = 1'b1;
    assign pslverr = acc && !mapped;

    // read data mux
    always_comb begin
        prdata = 32'h00000000;
        if (hit_ctrl) prdata = {20'h00000, remote_general_out, 3'h0, misstep_en, res_sel};
        else if (hit_cur) prdata = {16'h0000, 1'b0, still_pct, 1'b0, run_pct};
        else if (hit_acc) prdata = {decel_rate, accel_rate};
        else if (hit_band) prdata = {16'h0000, band};
        else if (hit_move) prdata = {7'h00, mv_dir, mv_travel};
        else if (hit_per) prdata = {16'h0000, period};
        else if (hit_stat) prdata = {27'h0000000, status};
        else if (hit_mask) prdata = {27'h0000000, mask};
        else if (hit_state) prdata = {17'h00000, div_q, st.busy, misstep_q, overheat_q,
                                      home_ready_q, home_set, excited_q};
    end

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    // configuration writes; out-of-range currents are limited
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_sel <= `SPO_RST_RES;
            misstep_en <= 1'b0;
            remote_general_out <= 4'h0;
            run_pct <= `SPO_RST_RUN_PCT;
            still_pct <= `SPO_RST_STILL_PCT;
            accel_rate <= `SPO_RST_ACCEL;
            decel_rate <= `SPO_RST_DECEL;
            band <= `SPO_RST_BAND;
            period <= `SPO_RST_PERIOD;
            mask <= 5'h00;
        end else if (wr) begin
            if (hit_ctrl) begin
                res_sel <= pwdata[`SPO_CTRL_RES_LSB +: 4];
                misstep_en <= pwdata[`SPO_CTRL_MSEN_BIT];
                remote_general_out <= pwdata[`SPO_CTRL_ROUT_LSB +: 4];
            end
            if (hit_cur) begin
                run_pct <= clamp_pct(pwdata[`SPO_CUR_RUN_LSB +: 8],
                                     `SPO_MIN_RUN_PCT, `SPO_MAX_RUN_PCT);
                still_pct <= clamp_pct(pwdata[`SPO_CUR_STILL_LSB +: 8],
                                       7'h00, `SPO_MAX_STILL_PCT);
            end
            if (hit_acc) begin
                accel_rate <= pwdata[15:0];
                decel_rate <= pwdata[31:16];
            end
            if (hit_band) band <= pwdata[15:0];
            if (hit_per) period <= pwdata[15:0];
            if (hit_mask) mask <= pwdata[`SPO_EV_COUNT-1:0];
        end
    end

    // move request; a write while busy is ignored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mv_travel <= 24'h000000;
            mv_dir <= 1'b0;
            mv_start <= 1'b0;
        end else begin
            mv_start <= wr && hit_move && !st.busy;
            if (wr && hit_move && !st.busy) begin
                mv_travel <= pwdata[23:0];
                mv_dir <= pwdata[`SPO_MOVE_DIR_BIT];
            end
        end
    end

    assign st.start = mv_start;
    assign st.travel = mv_travel;
    assign st.period = period;
    assign st.dir = mv_dir;

    spo_pulse_gen u_gen (
        .pclk(pclk),
        .presetn(presetn),
        .st(st.gen)
    );

    // ------------------------------------------------------------
    // home tracking
    // ------------------------------------------------------------
    wire excite_drop = excited_q && !excited;
    wire home_gain = home_seek_done || preset_apply || clear_cmd;
    wire home_lose = excite_drop && !misstep_en;
    wire next_home_ready = home_set && (cmd_pos == 24'h000000) && motor_at_rest;

    // home flag; cleared by reset and, while misstep_en is low, by unexcite; gain wins a tie
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            home_set <= 1'b0;
            pos_clear_req <= 1'b0;
            home_ready_q <= 1'b0;
        end else begin
            pos_clear_req <= clear_cmd;
            if (home_gain) home_set <= 1'b1;
            else if (home_lose) home_set <= 1'b0;
            home_ready_q <= next_home_ready;
        end
    end

    // ------------------------------------------------------------
    // index echo, overheat, misstep
    // ------------------------------------------------------------
    wire dev_hit = ({8'h00, band} <= abs_diff(enc_count, cmd_pos));
    wire excite_ok = (excite_cnt >= 25'(EXCITE_CYCLES));
    wire next_misstep = encoder_attached && misstep_en && excited && excite_ok &&
                        !home_seek_active && dev_hit;

    // excitation timer, restarts on every unexcited cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            excited_q <= 1'b0;
            excite_cnt <= 25'h0000000;
        end else begin
            excited_q <= excited;
            if (!excited) excite_cnt <= 25'h0000000;
            else if (!excite_ok) excite_cnt <= excite_cnt + 25'h0000001;
        end
    end

    // registered flag outputs, one cycle behind their causes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            index_q <= 1'b0;
            overheat_q <= 1'b0;
            misstep_q <= 1'b0;
        end else begin
            index_q <= encoder_attached && encoder_index_in;
            overheat_q <= overheat_warn;
            misstep_q <= next_misstep;
        end
    end

    // ------------------------------------------------------------
    // resolution and current
    // ------------------------------------------------------------
    // standstill level uses only its own setting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 9'h002;
            cur_q <= `SPO_RST_STILL_PCT;
        end else begin
            div_q <= res_to_div_x2(res_sel);
            cur_q <= motor_at_rest ? still_pct : run_pct;
        end
    end

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    wire [`SPO_EV_COUNT-1:0] ev = {st.done,
                                   next_misstep && !misstep_q,
                                   overheat_warn && !overheat_q,
                                   encoder_attached && encoder_index_in && !index_q,
                                   next_home_ready && !home_ready_q};
    wire stat_rd = rd && hit_stat;

    // sticky events, read clears, a new event wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) status <= 5'h00;
        else status <= (stat_rd ? 5'h00 : status) | ev;
    end

    assign irq = |(status & mask);

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign home_ready_out = home_ready_q;
    assign index_echo_out = index_q;
    assign overheat_out = overheat_q;
    assign misstep_out = misstep_q;
    assign step_pulse_out = st.step;
    assign dir_out = st.dir_q;
    assign div_x2 = div_q;
    assign coil_current_pct = cur_q;
endmodule : spo_top

/* File: hdl/spo_regs.svh */
// register offsets, field positions, reset values and timing counts
`ifndef SPO_REGS_SVH
`define SPO_REGS_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define SPO_OFS_CTRL     8'h00
`define SPO_OFS_CURRENT  8'h04
`define SPO_OFS_ACCEL    8'h08
`define SPO_OFS_BAND     8'h0C
`define SPO_OFS_MOVE     8'h10
`define SPO_OFS_PERIOD   8'h14
`define SPO_OFS_CMD      8'h18
`define SPO_OFS_STATUS   8'h1C
`define SPO_OFS_MASK     8'h20
`define SPO_OFS_STATE    8'h24

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define SPO_CTRL_RES_LSB    0
`define SPO_CTRL_MSEN_BIT   4
`define SPO_CTRL_ROUT_LSB   8
`define SPO_CUR_RUN_LSB     0
`define SPO_CUR_STILL_LSB   8
`define SPO_MOVE_DIR_BIT    24
`define SPO_CMD_CLEAR_BIT   0

// status / mask bits
`define SPO_EV_HOME_READY   0
`define SPO_EV_INDEX        1
`define SPO_EV_OVERHEAT     2
`define SPO_EV_MISSTEP      3
`define SPO_EV_MOVE_DONE    4
`define SPO_EV_COUNT        5

// ------------------------------------------------------------
// reset values and limits
// ------------------------------------------------------------
`define SPO_RST_RES         4'h0
`define SPO_RST_RUN_PCT     7'h64
`define SPO_RST_STILL_PCT   7'h32
`define SPO_MIN_RUN_PCT     7'h05
`define SPO_MAX_RUN_PCT     7'h64
`define SPO_MAX_STILL_PCT   7'h32
`define SPO_RST_ACCEL       16'h7530
`define SPO_RST_DECEL       16'h7530
`define SPO_RST_BAND        16'h0064
`define SPO_RST_PERIOD      16'h0064

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define SPO_CLK_HZ          50000000
`define SPO_MAX_STEP_HZ     500000
`define SPO_MIN_PERIOD      (`SPO_CLK_HZ / `SPO_MAX_STEP_HZ)
`define SPO_EXCITE_MS       500
`define SPO_EXCITE_CYCLES   ((`SPO_CLK_HZ / 1000) * `SPO_EXCITE_MS)

`endif

/* File: hdl/spo_pkg.sv */
// types shared by the stepper status and pulse output block
package spo_pkg;

    // pulse train sequencer states
    typedef enum logic [1:0] {
        SPO_PG_IDLE = 2'b00,
        SPO_PG_HIGH = 2'b01,
        SPO_PG_LOW  = 2'b10
    } spo_pg_state_t;

    typedef logic [23:0] spo_travel_t;
    typedef logic [15:0] spo_period_t;

endpackage : spo_pkg

/* File: hdl/spo_step_if.sv */
// carrier between the register side and the step pulse generator
`timescale 1ns/1ps
interface spo_step_if;
    logic start;
    spo_pkg::spo_travel_t travel;
    spo_pkg::spo_period_t period;
    logic dir;
    logic busy;
    logic done;
    logic step;
    logic dir_q;

    modport ctrl (output start, output travel, output period, output dir,
                  input busy, input done, input step, input dir_q);
    modport gen (input start, input travel, input period, input dir,
                 output busy, output done, output step, output dir_q);
endinterface : spo_step_if

/* File: hdl/spo_pulse_gen.sv */
// step pulse train generator: counted pulses at a programmed period
`timescale 1ns/1ps
`include "spo_regs.svh"
module spo_pulse_gen (
    input wire logic pclk,      // system clock
    input wire logic presetn,   // async reset, active low
    spo_step_if.gen st          // move request and pulse stream
);
    spo_pkg::spo_pg_state_t state, next_state;
    spo_pkg::spo_travel_t left;
    spo_pkg::spo_period_t per, cnt;
    logic dir_q;

    // half-period lengths; high time gets the rounding remainder
    wire [15:0] half_lo = {1'b0, per[15:1]};
    wire [15:0] half_hi = per - half_lo;
    wire cnt_end = (cnt == 16'h0001);
    wire last = (left == 24'h000001);
    wire go = st.start && (st.travel != 24'h000000);

    // sequencer next state
    always_comb begin
        next_state = state;
        unique case (state)
            spo_pkg::SPO_PG_IDLE: if (go) next_state = spo_pkg::SPO_PG_HIGH;
            spo_pkg::SPO_PG_HIGH: if (cnt_end) next_state = spo_pkg::SPO_PG_LOW;
            spo_pkg::SPO_PG_LOW: begin
                if (cnt_end) next_state = last ? spo_pkg::SPO_PG_IDLE : spo_pkg::SPO_PG_HIGH;
            end
            default: next_state = spo_pkg::SPO_PG_IDLE;
        endcase
    end

    // counters; one pulse per step of commanded travel
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= spo_pkg::SPO_PG_IDLE;
            left <= 24'h000000;
            per <= 16'h0064;
            cnt <= 16'h0000;
            dir_q <= 1'b0;
        end else begin
            state <= next_state;
            if (state == spo_pkg::SPO_PG_IDLE && go) begin
                left <= st.travel;
                per <= (st.period < 16'(`SPO_MIN_PERIOD)) ? 16'(`SPO_MIN_PERIOD) : st.period;
                cnt <= (st.period < 16'(`SPO_MIN_PERIOD)) ?
                       16'(`SPO_MIN_PERIOD) - {1'b0, 15'(`SPO_MIN_PERIOD / 2)} :
                       st.period - {1'b0, st.period[15:1]};
                dir_q <= st.dir;
            end else if (state == spo_pkg::SPO_PG_HIGH) begin
                cnt <= cnt_end ? half_lo : cnt - 16'h0001;
            end else if (state == spo_pkg::SPO_PG_LOW) begin
                cnt <= cnt_end ? half_hi : cnt - 16'h0001;
                if (cnt_end) left <= left - 24'h000001;
            end
        end
    end

    assign st.step = (state == spo_pkg::SPO_PG_HIGH);
    assign st.busy = (state != spo_pkg::SPO_PG_IDLE);
    assign st.done = (state == spo_pkg::SPO_PG_LOW) && cnt_end && last;
    assign st.dir_q = dir_q;
endmodule : spo_pulse_gen

/* File: verif/spo_top_chk.sv */
// concurrent checks on the block ports
`timescale 1ns/1ps
module spo_top_chk #(
    parameter int unsigned EXCITE_CYCLES = 20 // settle time
) (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset
    input wire logic psel, // apb select
    input wire logic penable, // apb access
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic home_seek_active, // homing running
    input wire logic excited, // windings on
    input wire logic motor_at_rest, // stopped
    input wire logic [23:0] cmd_pos, // commanded position
    input wire logic encoder_attached, // encoder present
    input wire logic encoder_index_in, // encoder index
    input wire logic overheat_warn, // overheat level
    input wire logic home_ready_out, // home ready
    input wire logic index_echo_out, // index echo
    input wire logic [3:0] remote_general_out, // remote outputs
    input wire logic overheat_out, // overheat flag
    input wire logic misstep_out, // misstep flag
    input wire logic step_pulse_out // step pulses
);
    logic [31:0] exc_cnt;
    // excited run length, saturating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            exc_cnt <= '0;
        else if (!excited)
            exc_cnt <= '0;
        else if (exc_cnt < EXCITE_CYCLES)
            exc_cnt <= exc_cnt + 32'h1;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    home_ready_a: assert property (home_ready_out |-> $past(cmd_pos) == 24'h0
        && $past(motor_at_rest)) else $error("home ready early");
    home_drop_a: assert property ((!motor_at_rest || cmd_pos != 24'h0) |=> !home_ready_out)
        else $error("home ready kept");
    index_echo_a: assert property ((encoder_attached && encoder_index_in) |=> index_echo_out)
        else $error("index not echoed");
    index_gate_a: assert property (!encoder_attached |=> !index_echo_out)
        else $error("stray index echo");
    overheat_on_a: assert property (overheat_warn |=> overheat_out)
        else $error("overheat missing");
    overheat_off_a: assert property (!overheat_warn |=> !overheat_out)
        else $error("overheat stuck");
    misstep_settle_a: assert property (misstep_out |-> exc_cnt >= EXCITE_CYCLES)
        else $error("misstep too early");
    misstep_home_a: assert property (home_seek_active |=> !misstep_out)
        else $error("misstep during homing");
    misstep_enc_a: assert property (!encoder_attached |=> !misstep_out)
        else $error("stray misstep");
    remote_out_a: assert property ((psel && penable && pwrite && paddr == 8'h00) |=>
        remote_general_out == $past(pwdata[11:8])) else $error("remote stale");
    pulse_width_a: assert property ($rose(step_pulse_out) |-> step_pulse_out [*8])
        else $error("step pulse too short");
endmodule : spo_top_chk

bind spo_top spo_top_chk #(.EXCITE_CYCLES(EXCITE_CYCLES)) u_chk (.*);

/* File: verif/spo_enc_model.sv */
// encoder model: held index pulse
`timescale 1ns/1ps
module spo_enc_model #(
    parameter int HOLD = 8 // index hold in clocks
) (
    input wire logic pclk, // clock
    input wire logic fire, // revolution mark
    output logic index // index line
);
    int cnt = 0; // clocks left high
    // hold index high
    always @(posedge pclk) begin
        if (fire)
            cnt <= HOLD;
        else if (cnt > 0)
            cnt <= cnt - 1;
    end
    assign index = (cnt > 0);
endmodule : spo_enc_model

/* File: verif/stepper_status_and_pulse_outputs_tb.sv */
// self-checking bench for the block
`timescale 1ns/1ps
module stepper_status_and_pulse_outputs_tb;
    logic pclk = 0, presetn, psel, penable, pwrite, pready, pslverr, irq, dir_out;
    logic home_seek_done, home_seek_active, preset_apply, excited, motor_at_rest, fire;
    logic encoder_attached, encoder_index_in, overheat_warn, pos_clear_req, home_ready_out;
    logic index_echo_out, overheat_out, misstep_out, step_pulse_out, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [23:0] cmd_pos, enc_count;
    logic [3:0] remote_general_out, rem;
    logic [8:0] div_x2;
    logic [6:0] coil_current_pct;
    logic [15:0] accel_rate, decel_rate;
    logic [7:0] run, still;
    int n_errors = 0, n_checks = 0, seed;
    int dtab[16] = '{2, 4, 5, 8, 10, 16, 20, 40, 50, 80, 100, 160, 200, 250, 400, 500};
    spo_top #(.EXCITE_CYCLES(20)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .home_seek_done, .home_seek_active, .preset_apply,
        .excited, .motor_at_rest, .cmd_pos, .enc_count, .encoder_attached, .encoder_index_in,
        .overheat_warn, .pos_clear_req, .home_ready_out, .index_echo_out, .remote_general_out,
        .overheat_out, .misstep_out, .step_pulse_out, .dir_out, .div_x2, .coil_current_pct,
        .accel_rate, .decel_rate, .irq);
    spo_enc_model #(.HOLD(8)) enc (.pclk, .fire, .index(encoder_index_in));
    always #10 pclk = ~pclk;
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 64);
        if (n == 64) n_errors++;
        q = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick
    function automatic logic [6:0] clamp(input logic [7:0] v, input int lo, input int hi);
        return (v < lo) ? 7'(lo) : (v > hi) ? 7'(hi) : v[6:0];
    endfunction : clamp
    task automatic move(input logic [23:0] t, input logic d);
        int cnt = 0, hi = 0, wmax = 0;
        apb(1'h1, 8'h10, {7'h0, d, t});
        repeat (t * 100 + 20) begin
            @(posedge pclk);
            if (step_pulse_out === 1'h1) begin
                if (hi == 0)
                    cnt++;
                hi++;
                wmax = (hi > wmax) ? hi : wmax;
                chk(dir_out, d);
            end else
                hi = 0;
        end
        chk(cnt, t);
        chk(wmax, 50);
    endtask : move
    task automatic print_verdict;
        if (n_errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    initial begin
        tick(20000);
        n_errors++;
        print_verdict;
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, home_seek_done, home_seek_active} = '0;
        {preset_apply, excited, cmd_pos, enc_count, encoder_attached, overheat_warn, fire} = '0;
        motor_at_rest = 1'h1;
        seed = $urandom(61061);
        tick(16);
        presetn <= 1'h1;
        apb(1'h0, 8'h04, 32'h0);
        chk(q, 32'h3264);
        chk(coil_current_pct, 7'h32);
        chk(accel_rate, 16'h7530);
        for (int i = 0; i < 6; i++) begin
            run = (i == 0) ? 8'h02 : (i == 1) ? 8'hC8 : 8'($urandom);
            still = (i == 2) ? 8'h33 : 8'($urandom);
            apb(1'h1, 8'h04, {16'h0, still, run});
            motor_at_rest <= 1'h0;
            tick(3);
            chk(coil_current_pct, clamp(run, 5, 100));
            motor_at_rest <= 1'h1;
            apb(1'h1, 8'h04, {16'h0, still, 8'($urandom)});
            tick(2);
            chk(coil_current_pct, clamp(still, 0, 50));
        end
        for (int i = 0; i < 16; i++) begin
            rem = 4'($urandom);
            apb(1'h1, 8'h00, {20'h0, rem, 4'h0, 4'(i)});
            tick(2);
            chk(div_x2, dtab[i]);
            chk(remote_general_out, rem);
        end
        excited <= 1'h1;
        tick(3);
        chk(home_ready_out, 1'h0);
        home_seek_done <= 1'h1;
        tick(1);
        home_seek_done <= 1'h0;
        tick(3);
        chk(home_ready_out, 1'h1);
        cmd_pos <= 24'h1 + 24'($urandom % 1000);
        tick(2);
        chk(home_ready_out, 1'h0);
        cmd_pos <= 24'h0;
        excited <= 1'h0;
        tick(2);
        excited <= 1'h1;
        tick(3);
        chk(home_ready_out, 1'h0);
        apb(1'h1, 8'h18, 32'h1);
        tick(3);
        chk(home_ready_out, 1'h1);
        excited <= 1'h0;
        tick(2);
        preset_apply <= 1'h1;
        tick(1);
        preset_apply <= 1'h0;
        excited <= 1'h1;
        tick(3);
        chk(home_ready_out, 1'h1);
        apb(1'h1, 8'h00, 32'h10);
        apb(1'h1, 8'h0C, 32'hA);
        encoder_attached <= 1'h1;
        enc_count <= 24'hA;
        excited <= 1'h0;
        tick(2);
        excited <= 1'h1;
        tick(6);
        chk(misstep_out, 1'h0);
        tick(30);
        chk(misstep_out, 1'h1);
        home_seek_active <= 1'h1;
        tick(2);
        chk(misstep_out, 1'h0);
        home_seek_active <= 1'h0;
        enc_count <= 24'h9;
        tick(2);
        chk(misstep_out, 1'h0);
        fire <= 1'h1;
        tick(1);
        fire <= 1'h0;
        tick(3);
        chk(index_echo_out, 1'h1);
        encoder_attached <= 1'h0;
        tick(2);
        chk(index_echo_out, 1'h0);
        apb(1'h0, 8'h1C, 32'h0);
        apb(1'h1, 8'h20, 32'h4);
        overheat_warn <= 1'h1;
        tick(3);
        chk(overheat_out, 1'h1);
        chk(irq, 1'h1);
        overheat_warn <= 1'h0;
        tick(2);
        chk(overheat_out, 1'h0);
        apb(1'h0, 8'h1C, 32'h0);
        chk(q[2], 1'h1);
        tick(1);
        chk(irq, 1'h0);
        apb(1'h0, 8'h3C, 32'h0);
        chk(q, 32'h0);
        chk(err, 1'h1);
        apb(1'h1, 8'h14, 32'h28);
        move(24'h1 + 24'($urandom % 3), 1'h1);
        move(24'h2, 1'h0);
        print_verdict;
    end
endmodule : stepper_status_and_pulse_outputs_tb
